// ===== verilog/mbx_pkg.sv
/*
  Constants and carrier types for the move and branch execution block.
  Assumes a 14-bit instruction word decoded upstream into an operation code.
*/
package mbx_pkg;
  localparam int PC_W        = 9;
  localparam int DATA_W      = 8;
  localparam int FILE_ADDR_W = 6;
  localparam int SPECIAL_W   = 4;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W        = 3;
  localparam logic [3:0] SPECIAL_MIN = 4'h6;
  localparam logic [3:0] SPECIAL_MAX = 4'hf;
  localparam logic [PC_W-1:0] PC_RESET = 9'h000;
  localparam logic [DATA_W-1:0] WORK_RESET = 8'h00;
  localparam logic [SP_W-1:0] SP_RESET = 3'h0;
  localparam int CALL_CYCLES = 2;
  localparam int SINGLE_CYCLES = 1;

  typedef enum logic [2:0] {
    OP_NONE, OP_IO_PAGE_STORE, OP_LONG_SUBROUTINE_CALL, OP_LONG_BRANCH,
    OP_LOAD_IMMEDIATE_WORK, OP_STORE_WORK_TO_FILE, OP_FILE_MOVE
  } op_e;

  typedef struct packed {
    logic                   valid;
    op_e                    op;
    logic [PC_W-1:0]        target;
    logic [DATA_W-1:0]      immediate;
    logic [FILE_ADDR_W-1:0] file_addr;
    logic [SPECIAL_W-1:0]   special_addr;
    logic                   dest_file;
  } instr_s;

  typedef struct packed {
    logic                   we;
    logic [FILE_ADDR_W-1:0] addr;
    logic [DATA_W-1:0]      data;
  } file_wr_s;

  typedef struct packed {
    logic                 we;
    logic [SPECIAL_W-1:0] addr;
    logic [DATA_W-1:0]    data;
  } special_wr_s;
endpackage : mbx_pkg

// ===== verilog/return_stack.sv
/*
  Return address stack with push only; pop belongs to the return logic.
  Assumes pushes arrive as one-cycle pulses on the core clock.
*/
`timescale 1ns/1ps
module return_stack import mbx_pkg::*; #(
  parameter int DEPTH = STACK_DEPTH
) (
  input  wire logic            clk,
  input  wire logic            reset_n,
  input  wire logic            push,
  input  wire logic [PC_W-1:0] push_addr,
  output logic [PC_W-1:0]      top,
  output logic [SP_W-1:0]      level
);
  logic [PC_W-1:0] mem [DEPTH];
  logic [SP_W-1:0] sp;

  // The stack wraps on overflow; the core offers no overflow trap.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sp <= SP_RESET;
    end else if (push) begin
      mem[sp] <= push_addr;
      sp      <= sp + 3'h1;
    end
  end

  assign top   = mem[sp - 3'h1];
  assign level = sp;
endmodule : return_stack

// ===== verilog/cpu_move_branch_exec.sv
/*
  Executes io-page store, long call, long branch, immediate load, store to file
  and file move. Assumes a data file with separate read and write ports, read combinationally.
*/
`timescale 1ns/1ps
// Behaviour
// - Io-page store copies work register to special register 6..15, one cycle.
// - Call pushes program counter plus one and raises stack level by one.
// - Call loads 9-bit target into program counter, two cycles, no flags.
// - Long branch loads 9-bit target, keeps stack and flags, two cycles.
// - Immediate load puts 8-bit operand in work register, no flags.
// - Store to file writes work register to file 0..63, no flags.
// - File move sends location to work register (d=0) or itself (d=1).
// - File move sets zero flag when moved value is zero, else clears.
module cpu_move_branch_exec import mbx_pkg::*; (
  input  wire logic              CLK,
  input  wire logic              RESET_N,
  input  instr_s                 INSTR,
  input  wire logic [DATA_W-1:0] FILE_RDATA,
  output logic [FILE_ADDR_W-1:0] FILE_RADDR,
  output file_wr_s               FILE_WR,
  output special_wr_s            SPECIAL_WR,
  output logic [PC_W-1:0]        PC,
  output logic [DATA_W-1:0]      WORK,
  output logic                   ZERO,
  output logic                   FLUSH,
  output logic                   BUSY,
  output logic [PC_W-1:0]        STACK_TOP,
  output logic [SP_W-1:0]        STACK_LEVEL
);
  typedef struct packed {
    logic [PC_W-1:0]   pc;
    logic [DATA_W-1:0] work;
    logic              zero;
    logic              refetch;
    file_wr_s          fwr;
    special_wr_s       swr;
    logic              push;
    logic [PC_W-1:0]   push_addr;
  } state_s;

  state_s st;
  state_s next_st;
  logic   exec;

  // Decoded strobes, one for each instruction of this group.
  // Each one is already qualified by the refetch slot.
  // At most one of them can be high at any clock edge.
  logic            take_io_store;
  logic            take_call;
  logic            take_branch;
  logic            take_load;
  logic            take_store;
  logic            take_move;

  // Helper values shared by several instructions.
  logic            special_in_range;
  logic            move_is_zero;
  logic [PC_W-1:0] pc_plus_one;

  // The word offered while refetch is high is the sequential fetch that the
  // jump has made stale.
  // It is dropped here rather than upstream, so that the fetch logic does not
  // need to know which instructions take two cycles.
  assign exec = INSTR.valid && !st.refetch;

  // One compare per operation code.
  // Keeping them apart makes each path easy to follow.
  assign take_io_store = exec && (INSTR.op == OP_IO_PAGE_STORE);
  assign take_call     = exec && (INSTR.op == OP_LONG_SUBROUTINE_CALL);
  assign take_branch   = exec && (INSTR.op == OP_LONG_BRANCH);
  assign take_load     = exec && (INSTR.op == OP_LOAD_IMMEDIATE_WORK);
  assign take_store    = exec && (INSTR.op == OP_STORE_WORK_TO_FILE);
  assign take_move     = exec && (INSTR.op == OP_FILE_MOVE);

  // Operands below the io page do not name a special register.
  // The write is suppressed, but the instruction still retires.
  // The counter therefore still advances for such an operand.
  assign special_in_range = (INSTR.special_addr >= SPECIAL_MIN) &&
                            (INSTR.special_addr <= SPECIAL_MAX);

  // The return address comes from the counter of the call itself.
  // It has to be formed before the target overwrites the counter.
  assign pc_plus_one = st.pc + 9'h001;

  // The flag follows the moved value for both destinations.
  // This lets software test a location for zero by moving it onto itself.
  assign move_is_zero = (FILE_RDATA == 8'h00);

  always_comb begin
    next_st         = st;

    // Write strobes and the push request are one-cycle pulses.
    // They fall by default and are raised only by the instruction that needs them.
    next_st.fwr.we  = 1'b0;
    next_st.swr.we  = 1'b0;
    next_st.push    = 1'b0;
    next_st.refetch = 1'b0;

    // Single-cycle instructions retire in order.
    // The counter steps by one unless a jump below overrides it.
    if (exec) begin
      next_st.pc = pc_plus_one;
    end

    if (take_io_store) begin
      // The work register is copied as it stands before this edge.
      // No status flag is touched here.
      if (special_in_range) begin
        next_st.swr.we   = 1'b1;
        next_st.swr.addr = INSTR.special_addr;
        next_st.swr.data = st.work;
      end
    end else if (take_call) begin
      // The push is registered and applied by the stack on the next edge.
      // The stack level therefore moves one cycle after the counter.
      next_st.push      = 1'b1;
      next_st.push_addr = pc_plus_one;
      next_st.pc        = INSTR.target;
      next_st.refetch   = 1'b1;
    end else if (take_branch) begin
      // A branch leaves the stack alone and only redirects the counter.
      next_st.pc      = INSTR.target;
      next_st.refetch = 1'b1;
    end else if (take_load) begin
      // The immediate replaces the work register; the flags keep their value.
      next_st.work = INSTR.immediate;
    end else if (take_store) begin
      // The file write is registered, so the data file sees it one cycle later.
      next_st.fwr.we   = 1'b1;
      next_st.fwr.addr = INSTR.file_addr;
      next_st.fwr.data = st.work;
    end else if (take_move) begin
      // The read data is used in the cycle in which the instruction is taken.
      // The data file must answer combinationally for this to hold.
      if (INSTR.dest_file) begin
        next_st.fwr.we   = 1'b1;
        next_st.fwr.addr = INSTR.file_addr;
        next_st.fwr.data = FILE_RDATA;
      end else begin
        next_st.work = FILE_RDATA;
      end
      next_st.zero = move_is_zero;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      st         <= '0;
      st.pc      <= PC_RESET;
      st.work    <= WORK_RESET;
    end else begin
      st <= next_st;
    end
  end

  return_stack #(
    .DEPTH(STACK_DEPTH)
  ) u_stack (
    .clk       (CLK),
    .reset_n   (RESET_N),
    .push      (st.push),
    .push_addr (st.push_addr),
    .top       (STACK_TOP),
    .level     (STACK_LEVEL)
  );

  // The read address follows the instruction word directly.
  // A registered address would return the data one cycle too late.
  assign FILE_RADDR = INSTR.file_addr;

  // The write ports are driven straight from the state registers.
  // This keeps the write, counter, work and flag outputs on flip-flops.
  // A strobe falls again on the next edge unless the next instruction also writes that port.
  assign FILE_WR    = st.fwr;
  assign SPECIAL_WR = st.swr;
  assign PC         = st.pc;
  assign WORK       = st.work;
  assign ZERO       = st.zero;

  // The discarded slot is the one already fetched behind the jump.
  // Fetch logic uses this flag to replace that slot by a fresh fetch.
  // It stays high for exactly one cycle after a call or a branch.
  assign FLUSH      = st.refetch;
  assign BUSY       = st.refetch;
endmodule : cpu_move_branch_exec

// ===== dv/mbx_sva.sv
/* Port assertions for cpu_move_branch_exec.
   Assumes sync active-low reset and at most one instruction taken per edge. */
`timescale 1ns/1ps
module mbx_sva import mbx_pkg::*; (
  input wire logic CLK, RESET_N, ZERO, FLUSH,
  input instr_s INSTR,
  input wire logic [DATA_W-1:0] FILE_RDATA, WORK,
  input file_wr_s FILE_WR,
  input special_wr_s SPECIAL_WR,
  input wire logic [PC_W-1:0] PC, STACK_TOP,
  input wire logic [SP_W-1:0] STACK_LEVEL
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  wire tk = INSTR.valid && !FLUSH;
  wire cl = tk && INSTR.op == OP_LONG_SUBROUTINE_CALL;
  wire br = tk && INSTR.op == OP_LONG_BRANCH;
  wire mv = tk && INSTR.op == OP_FILE_MOVE;
  sequence dead_s; FLUSH ##1 !FLUSH; endsequence
  io_store_a: assert property (tk && INSTR.op == OP_IO_PAGE_STORE &&
    INSTR.special_addr >= SPECIAL_MIN |=> SPECIAL_WR.we && SPECIAL_WR.data == $past(WORK))
    else $error("io store lost");
  call_push_a: assert property (cl |=> ##1 STACK_LEVEL == $past(STACK_LEVEL, 2) + 3'h1 &&
    STACK_TOP == $past(PC, 2) + 9'h1) else $error("call push wrong");
  call_pc_a: assert property (cl |=> PC == $past(INSTR.target) && $stable(ZERO))
    else $error("call target wrong");
  branch_pc_a: assert property (br |=> PC == $past(INSTR.target) &&
    $stable(STACK_LEVEL) ##1 $stable(STACK_LEVEL)) else $error("branch wrong");
  load_work_a: assert property (tk && INSTR.op == OP_LOAD_IMMEDIATE_WORK |=>
    WORK == $past(INSTR.immediate) && $stable(ZERO)) else $error("load wrong");
  file_store_a: assert property (tk && INSTR.op == OP_STORE_WORK_TO_FILE |=>
    FILE_WR.we && FILE_WR.data == $past(WORK) && FILE_WR.addr == $past(INSTR.file_addr))
    else $error("file store wrong");
  move_dest_a: assert property (mv |=> $past(INSTR.dest_file) ?
    FILE_WR.we && FILE_WR.data == $past(FILE_RDATA) : WORK == $past(FILE_RDATA))
    else $error("move wrong");
  zero_flag_a: assert property (mv |=> ZERO == ($past(FILE_RDATA) == 8'h00))
    else $error("zero flag wrong");
  refetch_a: assert property (cl || br |=> dead_s) else $error("no refetch");
endmodule : mbx_sva
bind cpu_move_branch_exec mbx_sva u_chk(.CLK(CLK), .RESET_N(RESET_N), .ZERO(ZERO),
  .FLUSH(FLUSH), .INSTR(INSTR), .FILE_RDATA(FILE_RDATA), .WORK(WORK), .FILE_WR(FILE_WR),
  .SPECIAL_WR(SPECIAL_WR), .PC(PC), .STACK_TOP(STACK_TOP), .STACK_LEVEL(STACK_LEVEL));

// ===== dv/cpu_move_branch_exec_bench.sv
/* Random bench for cpu_move_branch_exec; the bench plays the data file.
   Assumes results show one edge after the instruction is taken. */
`timescale 1ns/1ps
module cpu_move_branch_exec_bench import mbx_pkg::*; ();
  logic CLK = 0, RESET_N = 0, ZERO, FLUSH, z = 0, dead = 0, p = 0, fw, sw;
  instr_s INSTR = '0;
  logic [7:0] FILE_RDATA = 0, WORK, w = 0;
  logic [8:0] PC, pc = 0;
  logic [2:0] STACK_LEVEL, lv = 0;
  logic BUSY, tv = 0;
  logic [5:0] FILE_RADDR, fa = 0;
  logic [3:0] sa = 0;
  logic [7:0] fd = 0, sd = 0;
  logic [8:0] STACK_TOP, ra = 0, tp = 0;
  logic [31:0] r = 83;
  file_wr_s FILE_WR;
  special_wr_s SPECIAL_WR;
  int n_errors = 0, cmp_count = 0;
  cpu_move_branch_exec u_dut(.CLK(CLK), .RESET_N(RESET_N), .INSTR(INSTR), .FILE_RDATA(FILE_RDATA),
    .FILE_RADDR(FILE_RADDR), .FILE_WR(FILE_WR), .SPECIAL_WR(SPECIAL_WR), .PC(PC), .WORK(WORK),
    .ZERO(ZERO), .FLUSH(FLUSH), .BUSY(BUSY), .STACK_TOP(STACK_TOP), .STACK_LEVEL(STACK_LEVEL));
  function logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction : xs
  task chk(input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("Error %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  task give_verdict;
    if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  initial forever #25 CLK = ~CLK;
  initial begin
    #100000;
    n_errors++;
    give_verdict;
  end
  initial begin
    repeat (16) @(negedge CLK);
    RESET_N = 1;
    for (int k = 0; k < 300; k++) begin
      r = xs(r);
      // The slot after a call or branch also carries a random word, which must be dropped.
      INSTR = {r[31], 3'(k % 6 + 1), r[27:0]};
      FILE_RDATA = r[7] ? 8'h00 : r[15:8];
      fw = 0;
      sw = 0;
      if (dead) begin
        lv += 3'(p);
        if (p) begin
          tp = ra;
          tv = 1;
        end
        dead = 0;
      end else if (INSTR.valid) begin
        fw = INSTR.op == OP_STORE_WORK_TO_FILE || INSTR.op == OP_FILE_MOVE && INSTR.dest_file;
        fa = INSTR.file_addr;
        fd = INSTR.op == OP_FILE_MOVE ? FILE_RDATA : w;
        sw = INSTR.op == OP_IO_PAGE_STORE && INSTR.special_addr >= SPECIAL_MIN;
        sa = INSTR.special_addr;
        sd = w;
        p = INSTR.op == OP_LONG_SUBROUTINE_CALL;
        if (p) ra = pc + 9'h1;
        dead = p || INSTR.op == OP_LONG_BRANCH;
        if (dead) pc = INSTR.target;
        else pc++;
        if (INSTR.op == OP_LOAD_IMMEDIATE_WORK) w = INSTR.immediate;
        if (INSTR.op == OP_FILE_MOVE) begin
          z = FILE_RDATA == 8'h00;
          if (!INSTR.dest_file) w = FILE_RDATA;
        end
      end
      @(negedge CLK);
      chk({PC, WORK, ZERO}, {pc, w, z});
      chk({STACK_LEVEL, FILE_WR.we, SPECIAL_WR.we}, {lv, fw, sw});
      chk(fw ? {FILE_WR.addr, FILE_WR.data} : 14'h0, fw ? {fa, fd} : 14'h0);
      chk(sw ? {SPECIAL_WR.addr, SPECIAL_WR.data} : 12'h0, sw ? {sa, sd} : 12'h0);
      chk(tv ? STACK_TOP : 9'h0, tp);
      chk({FLUSH, BUSY, FILE_RADDR}, {dead, dead, INSTR.file_addr});
    end
    give_verdict;
  end
endmodule : cpu_move_branch_exec_bench
